// ### hdl/spi_serial_irq.sv
// Purpose: Interrupt enable and event identification of a serial port
// Assumes: Event inputs come from logic on sys_clk; APB slave, zero wait
// Notes: Unmapped addresses read zero and answer with pslverr
// Overview of operation
// - Enable bit 1 allows transmit low level, code 0010
// - Enable bit 2 allows line status, code 0110
// - Enable bit 3 allows modem status, code 0000
// - Upper four enable bits reserved when not extended
// - Extended bit 0 enables receive threshold or timeout
// - Extended bit 1 enables transmit low level
// - Extended bit 4 enables DMA terminal count
// - Extended bit 5 enables transmitter fully drained
// - Consumer infrared bit 2: line status or underrun
// - Consumer infrared other bits as extended mode only with extended bit 0 also set
// - Index two reads identification, writes queue control
// - Non-extended reports single highest of four levels
// - Identification frozen during its read access
// - Bit 0 low while pending, idle reads 0001
// - Bits 2 and 1 encode highest pending level
// - Bit 3 set only for timeout with queues on
// - Bits 7 and 6 follow queue enable bit, forced set in consumer infrared
// - Line status highest, cleared by line state read
// - Receive data second, cleared by data read
// - Receive timeout second, cleared by data read
// - Transmit low third, cleared by ident read showing it as highest, or data port write
// - Modem status lowest, cleared by modem state read
// - Enable bits 4-5 writable only when extended
// - Enable register resets in non-extended layout
`timescale 1ns/1ps
module spi_serial_irq (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_error,
  input wire logic rx_level_high,
  input wire logic rx_timeout,
  input wire logic tx_level_low,
  input wire logic tx_underrun,
  input wire logic tx_drained,
  input wire logic terminal_count,
  input wire logic dma_on,
  input wire logic modem_change,
  output logic [7:0] queue_control_reg,
  output logic queue_control_wr,
  output logic rx_data_read,
  output logic irq
);

  logic [7:0] irq_enable_reg;
  logic [7:0] next_irq_enable_reg;
  logic [7:0] next_queue_control_reg;
  logic [1:0] extended_control_one;
  logic [1:0] next_extended_control_one;
  logic line_event;
  logic next_line_event;
  logic modem_event;
  logic next_modem_event;
  logic tx_event;
  logic next_tx_event;
  logic tc_event;
  logic next_tc_event;
  logic [7:0] ident_hold;
  logic [7:0] next_ident_hold;
  logic ident_busy;
  logic next_ident_busy;
  logic next_queue_control_wr;
  logic next_rx_data_read;
  logic tx_level_low_q;
  logic next_tx_level_low_q;
  // Word indices widened once to the decoded address width
  localparam logic [9:0] IE_IX = 10'(spi_pkg::IRQ_ENABLE_IDX);
  localparam logic [9:0] ID_IX = 10'(spi_pkg::EVENT_IDENT_IDX);
  localparam logic [9:0] LS_IX = 10'(spi_pkg::LINE_STATE_IDX);
  localparam logic [9:0] MS_IX = 10'(spi_pkg::MODEM_STATE_IDX);
  localparam logic [9:0] DP_IX = 10'(spi_pkg::DATA_PORT_IDX);
  localparam logic [9:0] XC_IX = 10'(spi_pkg::EXT_CONTROL_IDX);

  logic extended_select;
  logic cir_mode;
  logic queues_on;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [9:0] addr;
  logic hit;
  logic [7:0] ident_live;
  logic [3:0] code;
  logic none_pending_flag;
  logic line_pend;
  logic line_ok;

  assign addr = paddr[11:2];
  assign extended_select = extended_control_one[spi_pkg::EXT_SEL_BIT];
  assign cir_mode = extended_control_one[spi_pkg::CIR_SEL_BIT];
  // Consumer infrared runs its queues always on
  assign queues_on = queue_control_reg[spi_pkg::QUEUE_ON_BIT] | cir_mode;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign hit = (addr == spi_pkg::IRQ_ENABLE_ADDR[9:0] >> 2) |
               (addr == spi_pkg::EVENT_IDENT_ADDR[9:0] >> 2) |
               (addr == spi_pkg::LINE_STATE_ADDR[9:0] >> 2) |
               (addr == spi_pkg::MODEM_STATE_ADDR[9:0] >> 2) |
               (addr == spi_pkg::DATA_PORT_ADDR[9:0] >> 2) |
               (addr == spi_pkg::EXT_CONTROL_ADDR[9:0] >> 2);
  assign pslverr = psel & penable & ~hit;

  // Line source widens to underrun in consumer infrared
  assign line_pend = line_event | (cir_mode & tx_underrun);

  // Priority encoder over enabled pending sources
  always_comb begin
    code = spi_pkg::CODE_NONE;
    if (line_pend & irq_enable_reg[spi_pkg::LINE_BIT]) begin
      code = spi_pkg::CODE_LINE;
    end else if (rx_timeout & queues_on & irq_enable_reg[spi_pkg::RX_BIT]) begin
      code = spi_pkg::CODE_TIMEOUT;
    end else if (rx_level_high & irq_enable_reg[spi_pkg::RX_BIT]) begin
      code = spi_pkg::CODE_RX;
    end else if (tx_event & irq_enable_reg[spi_pkg::TX_BIT]) begin
      code = spi_pkg::CODE_TX;
    end else if (modem_event & irq_enable_reg[spi_pkg::MODEM_BIT]) begin
      code = spi_pkg::CODE_MODEM;
    end
  end

  assign none_pending_flag = code[0];
  // Only the single highest level is shown in legacy format
  assign ident_live = {{2{queues_on}}, 2'b00, code};

  // Event flags: hardware set wins over a read clear
  always_comb begin
    next_line_event = line_event;
    next_modem_event = modem_event;
    next_tx_event = tx_event;
    next_tc_event = tc_event;
    if (rd_acc & (addr == LS_IX)) begin
      next_line_event = 1'b0;
    end
    if (rd_acc & (addr == MS_IX)) begin
      next_modem_event = 1'b0;
    end
    // Ident read clears transmit only when it was displayed highest
    if (rd_acc & (addr == ID_IX) &
        (ident_hold[3:0] == spi_pkg::CODE_TX)) begin
      next_tx_event = 1'b0;
    end
    if (wr_acc & (addr == DP_IX)) begin
      next_tx_event = 1'b0;
    end
    if (rd_acc & (addr == ID_IX)) begin
      next_tc_event = 1'b0;
    end
    if (line_error) begin
      next_line_event = 1'b1;
    end
    if (modem_change) begin
      next_modem_event = 1'b1;
    end
    // Only a rising low level sets it, so a read clear sticks
    if (tx_level_low & ~tx_level_low_q & ~(wr_acc & (addr == DP_IX))) begin
      next_tx_event = 1'b1;
    end
    if (terminal_count & dma_on) begin
      next_tc_event = 1'b1;
    end
  end

  assign next_tx_level_low_q = tx_level_low;

  // Register access and identification freeze
  always_comb begin
    next_irq_enable_reg = irq_enable_reg;
    next_queue_control_reg = queue_control_reg;
    next_extended_control_one = extended_control_one;
    next_ident_hold = ident_hold;
    next_ident_busy = ident_busy;
    next_queue_control_wr = 1'b0;
    next_rx_data_read = 1'b0;
    if (wr_acc & pstrb[0]) begin
      if (addr == IE_IX) begin
        next_irq_enable_reg[3:0] = pwdata[3:0];
        if (extended_select) begin
          // Bits 7 and 6 stay reserved even when extended
          next_irq_enable_reg[5:4] = pwdata[5:4];
        end
      end
      if (addr == ID_IX) begin
        next_queue_control_reg = pwdata[7:0];
        next_queue_control_wr = 1'b1;
      end
      if (addr == XC_IX) begin
        next_extended_control_one = pwdata[1:0];
      end
    end
    if (~extended_select) begin
      next_irq_enable_reg[7:4] = 4'h0;
    end
    // Snapshot at setup, held through the access phase
    if (setup & ~pwrite & (addr == ID_IX)) begin
      next_ident_hold = ident_live;
      next_ident_busy = 1'b1;
    end else if (~psel) begin
      next_ident_busy = 1'b0;
      next_ident_hold = ident_live;
    end else if (~ident_busy) begin
      next_ident_hold = ident_live;
    end
    if (rd_acc & (addr == DP_IX)) begin
      next_rx_data_read = 1'b1;
    end
  end

  // Read data mux, combinational onto the registered hold
  always_comb begin
    prdata = 32'h00000000;
    if (psel & penable & ~pwrite) begin
      unique case (addr)
        IE_IX: prdata = {24'h000000, irq_enable_reg};
        ID_IX: prdata = {24'h000000, ident_hold};
        XC_IX: prdata = {30'h00000000, extended_control_one};
        LS_IX: prdata = {31'h00000000, line_pend};
        MS_IX: prdata = {31'h00000000, modem_event};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_reg <= spi_pkg::IRQ_ENABLE_RESET;
      queue_control_reg <= spi_pkg::QUEUE_CONTROL_RESET;
      extended_control_one <= spi_pkg::EXT_CONTROL_RESET;
      line_event <= 1'b0;
      modem_event <= 1'b0;
      tx_event <= 1'b0;
      tc_event <= 1'b0;
      tx_level_low_q <= 1'b0;
      ident_hold <= {4'h0, spi_pkg::CODE_NONE};
      ident_busy <= 1'b0;
      queue_control_wr <= 1'b0;
      rx_data_read <= 1'b0;
    end else begin
      irq_enable_reg <= next_irq_enable_reg;
      queue_control_reg <= next_queue_control_reg;
      extended_control_one <= next_extended_control_one;
      line_event <= next_line_event;
      modem_event <= next_modem_event;
      tx_event <= next_tx_event;
      tc_event <= next_tc_event;
      tx_level_low_q <= next_tx_level_low_q;
      ident_hold <= next_ident_hold;
      ident_busy <= next_ident_busy;
      queue_control_wr <= next_queue_control_wr;
      rx_data_read <= next_rx_data_read;
    end
  end

  // Extended sources join the request without an ident code
  assign line_ok = ~none_pending_flag;
  assign irq = line_ok |
               (tc_event & irq_enable_reg[spi_pkg::TC_BIT]) |
               (tx_drained & irq_enable_reg[spi_pkg::DRAIN_BIT]);

endmodule : spi_serial_irq

// ### pkg/spi_pkg.sv
// Purpose: Constants for the serial port interrupt enable and identification
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are kept; byte address is four times the index
package spi_pkg;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h01;
  localparam logic [7:0] EVENT_IDENT_IDX = 8'h02;
  localparam logic [7:0] LINE_STATE_IDX = 8'h05;
  localparam logic [7:0] MODEM_STATE_IDX = 8'h06;
  localparam logic [7:0] DATA_PORT_IDX = 8'h00;
  localparam logic [7:0] EXT_CONTROL_IDX = 8'h08;
  localparam logic [9:0] IRQ_ENABLE_ADDR = {IRQ_ENABLE_IDX, 2'b00};
  localparam logic [9:0] EVENT_IDENT_ADDR = {EVENT_IDENT_IDX, 2'b00};
  localparam logic [9:0] LINE_STATE_ADDR = {LINE_STATE_IDX, 2'b00};
  localparam logic [9:0] MODEM_STATE_ADDR = {MODEM_STATE_IDX, 2'b00};
  localparam logic [9:0] DATA_PORT_ADDR = {DATA_PORT_IDX, 2'b00};
  localparam logic [9:0] EXT_CONTROL_ADDR = {EXT_CONTROL_IDX, 2'b00};
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] QUEUE_CONTROL_RESET = 8'h00;
  localparam logic [1:0] EXT_CONTROL_RESET = 2'h0;
  localparam int RX_BIT = 0;
  localparam int TX_BIT = 1;
  localparam int LINE_BIT = 2;
  localparam int MODEM_BIT = 3;
  localparam int TC_BIT = 4;
  localparam int DRAIN_BIT = 5;
  localparam int QUEUE_ON_BIT = 0;
  localparam int EXT_SEL_BIT = 0;
  localparam int CIR_SEL_BIT = 1;
  localparam logic [3:0] CODE_NONE = 4'h1;
  localparam logic [3:0] CODE_LINE = 4'h6;
  localparam logic [3:0] CODE_RX = 4'h4;
  localparam logic [3:0] CODE_TIMEOUT = 4'hC;
  localparam logic [3:0] CODE_TX = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  localparam logic [3:0] LOW_NIBBLE_MASK = 4'hF;
endpackage : spi_pkg

// ### tb/spi_host.sv
// Purpose: Host side bus master for the serial interrupt block
// Assumes: APB, one transfer at a time, request held until pready
// Notes: Released write data shows the inverse, never the last value
`timescale 1ns/1ps
module spi_host (
  input wire logic sys_clk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end

  // Entered just after a rising edge; leaves one idle edge behind it
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask : xfer
endmodule : spi_host

// ### tb/spi_irq_chk.sv
// Purpose: Bus and identification checks on the serial interrupt block
// Assumes: One clock domain, ports of the top module only
// Notes: Extended mode is tracked from the host's own writes
`timescale 1ns/1ps
module spi_irq_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] queue_control_reg,
  input wire logic queue_control_wr,
  input wire logic rx_data_read
);
  logic ext;
  logic next_ext;
  wire acc = psel && penable;
  wire id_rd = acc && !pwrite && paddr == 12'h008;
  wire qc_wr = acc && pwrite && pstrb[0] && paddr == 12'h008;
  wire bad = !(paddr[11:2] inside
    {10'h000, 10'h001, 10'h002, 10'h005, 10'h006, 10'h008});
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_comb begin
    next_ext = ext;
    if (acc && pwrite && pstrb[0] && paddr == 12'h020) begin
      next_ext = pwdata[0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext <= 1'b0;
    end else begin
      ext <= next_ext;
    end
  end
  ready_high_a: assert property (pready)
    else $error("pready low");
  ident_fen_a: assert property (id_rd |->
    prdata[7:6] == {2{queue_control_reg[0]}}) else $error("fen bits");
  ident_idle_a: assert property (id_rd && prdata[0] |->
    prdata[5:1] == 5'h00) else $error("idle code");
  timeout_code_a: assert property (id_rd && prdata[3] |->
    prdata[2:0] == 3'h4 && queue_control_reg[0]) else $error("receive_timeout_flag");
  qc_write_a: assert property (qc_wr |=> queue_control_wr &&
    queue_control_reg == $past(pwdata[7:0])) else $error("qc write");
  qc_pulse_a: assert property (queue_control_wr |->
    $past(qc_wr) ##1 !queue_control_wr) else $error("qc pulse");
  data_read_a: assert property (acc && !pwrite && paddr == 12'h000
    |=> rx_data_read) else $error("data read pulse");
  unmapped_a: assert property (acc && bad |->
    pslverr && prdata == 32'h0) else $error("unmapped");
  enable_upper_a: assert property (acc && !pwrite &&
    paddr == 12'h004 |-> prdata[7:6] == 2'h0 &&
    (ext || prdata[5:4] == 2'h0)) else $error("enable upper");
  cover property (id_rd && !prdata[0]);
  cover property (id_rd && prdata[3]);
  cover property (acc && bad);
endmodule : spi_irq_chk

bind spi_serial_irq spi_irq_chk chk (.*);

// ### tb/tb.sv
// Purpose: Self-checking bench of the serial interrupt block
// Assumes: Zero wait slave; notes hold {pslverr, irq, byte}
// Notes: Upper note half masks don't-care bits
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module tb;
  logic sys_clk, rst_b, line_error, rx_level_high, rx_timeout;
  logic tx_level_low, tx_underrun, tx_drained, terminal_count, dma_on;
  logic modem_change, psel, penable, pwrite, pready, pslverr, irq;
  logic queue_control_wr, rx_data_read;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] queue_control_reg;
  logic [19:0] notes[$];
  logic [19:0] n;
  int mismatches, checks, cycles;
  int seed = 32'h9f883802;
  spi_serial_irq dut (.*);
  spi_host h (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic tick(int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  task automatic wr(logic [11:0] a, logic [31:0] d);
    h.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [9:0] e, logic [9:0] m = 10'h3FF);
    notes.push_back({m, e});
    h.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic fin(string s);
    $display("test %s done", s);
  endtask : fin
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Results are judged when the access phase completes
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      `CHK("read", n[9:0] & n[19:10], {pslverr, irq, prdata[7:0]} & n[19:10])
    end
  end
  initial begin
    {line_error, rx_level_high, rx_timeout, tx_level_low, tx_underrun} = '0;
    {tx_drained, terminal_count, dma_on, modem_change} = '0;
    rst_b = 1'b0;
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    rd(12'h004, 10'h000);
    rd(12'h008, 10'h001);
    rd(12'h00C, 10'h200);
    wr(12'h004, $random(seed) | 32'h0F);
    rd(12'h004, 10'h00F);
    fin("reset");
    line_error <= 1'b1;
    modem_change <= 1'b1;
    tick(1);
    line_error <= 1'b0;
    modem_change <= 1'b0;
    tick(1);
    rd(12'h008, 10'h106);
    rd(12'h014, 10'h001, 10'h001);
    rd(12'h008, 10'h100);
    rd(12'h018, 10'h001, 10'h001);
    rd(12'h008, 10'h001);
    tx_level_low <= 1'b1;
    tick(2);
    rd(12'h008, 10'h102);
    rd(12'h008, 10'h001);
    tx_level_low <= 1'b0;
    rx_level_high <= 1'b1;
    tick(2);
    rd(12'h008, 10'h104);
    wr(12'h004, 32'h05);
    line_error <= 1'b1;
    tick(1);
    line_error <= 1'b0;
    tick(1);
    rd(12'h008, 10'h106);
    rd(12'h014, 10'h001, 10'h001);
    rd(12'h000, 10'h100, 10'h300);
    rx_level_high <= 1'b0;
    fin("priority");
    wr(12'h008, 32'h01);
    rx_timeout <= 1'b1;
    tick(2);
    rd(12'h008, 10'h1CC);
    rx_timeout <= 1'b0;
    wr(12'h008, 32'h00);
    rd(12'h008, 10'h001);
    fin("queues");
    wr(12'h020, 32'h01);
    wr(12'h004, 32'hFF);
    rd(12'h004, 10'h03F);
    wr(12'h004, 32'h10);
    dma_on <= 1'b1;
    terminal_count <= 1'b1;
    tick(1);
    terminal_count <= 1'b0;
    tick(1);
    rd(12'h004, 10'h110);
    rd(12'h008, 10'h100, 10'h100);
    rd(12'h004, 10'h010);
    wr(12'h004, 32'h20);
    tx_drained <= 1'b1;
    tick(1);
    rd(12'h004, 10'h120);
    tx_drained <= 1'b0;
    wr(12'h020, 32'h03);
    wr(12'h004, 32'h34);
    tx_underrun <= 1'b1;
    tick(1);
    rd(12'h004, 10'h134);
    tx_underrun <= 1'b0;
    wr(12'h020, 32'h00);
    rd(12'h004, 10'h004);
    fin("extended");
    test_done();
  end
endmodule : tb
